// [rtl/gdd_pkg.sv]
// Package of constants, types and helpers for the port direction and drive control block
package gdd_pkg;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int NPORT = 4;
    localparam int NPIN  = 26;
    localparam int PIN_BASE_A = 0;
    localparam int PIN_BASE_B = 8;
    localparam int PIN_BASE_C = 15;
    localparam int PIN_BASE_D = 22;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [1:0] SUB_DATA    = 2'h0;
    localparam logic [1:0] SUB_DIR     = 2'h1;
    localparam logic [1:0] SUB_PULL    = 2'h2;
    localparam logic [7:0] ADDR_WAKE   = 8'h03;
    localparam logic [7:0] ADDR_DRV_AB = 8'h10;
    localparam logic [7:0] ADDR_DRV_CD = 8'h11;
    localparam logic [7:0] ADDR_ANA    = 8'h12;
    localparam logic [7:0] ADDR_ADC    = 8'h13;
    localparam int         ADC_EN_BIT  = 0;

    // ------------------------------------------------------------
    // Implemented-bit masks, index 0 is port A
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_PORT_A     = 8'hFF;
    localparam logic [7:0] MASK_PORT_B     = 8'h7F;
    localparam logic [7:0] MASK_PORT_C     = 8'h7F;
    localparam logic [7:0] MASK_PORT_D_LRG = 8'h0F;
    localparam logic [7:0] MASK_PORT_D_SML = 8'h00;
    localparam logic [7:0] MASK_DRV_AB     = 8'hFF;
    localparam logic [7:0] MASK_DRV_CD_LRG = 8'h3F;
    localparam logic [7:0] MASK_DRV_CD_SML = 8'h0F;
    localparam logic [7:0] MASK_ADC        = 8'h01;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DATA   = 8'hFF;
    localparam logic [7:0] RST_DIR    = 8'hFF;
    localparam logic [7:0] RST_PULL   = 8'h00;
    localparam logic [7:0] RST_WAKE   = 8'h00;
    localparam logic [7:0] RST_DRV_AB = 8'h55;
    localparam logic [7:0] RST_DRV_CD = 8'h15;
    localparam logic [7:0] RST_ANA    = 8'hFF;
    localparam logic [7:0] RST_ADC    = 8'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_0 = 2'b00,
        LVL_1 = 2'b01,
        LVL_2 = 2'b10,
        LVL_3 = 2'b11
    } gdd_level_e;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_RMW_RD = 3'b010,
        ST_RMW_WR = 3'b100
    } gdd_state_e;

    typedef struct packed {
        logic       dout;
        logic       oe;
        logic       pull;
        gdd_level_e level;
    } gdd_pad_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic       bit_set;
        logic [2:0] bit_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gdd_cpu_s;

    // Bit position of a pin's level field in {drive_cd, drive_ab}
    function automatic int lvl_pos(input int pin);
        if (pin < 4)       lvl_pos = 0;
        else if (pin < 8)  lvl_pos = 2;
        else if (pin < 12) lvl_pos = 4;
        else if (pin < 15) lvl_pos = 6;
        else if (pin < 19) lvl_pos = 8;
        else if (pin < 22) lvl_pos = 10;
        else               lvl_pos = 12;
    endfunction

endpackage

// [rtl/gdd_wake_det.sv]
// Port A high-to-low wake detector
`timescale 1ns/1ps
`default_nettype none
module gdd_wake_det (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic       sleep_mode,
    input  wire logic [7:0] pin_a,
    input  wire logic [7:0] wake_en,
    output logic            wake_ff
);
    import gdd_pkg::*;

    logic [7:0] prev_ff;
    logic [7:0] nxt_fall;

    // ------------------------------------------------------------
    // Falling edge per enabled pin
    // ------------------------------------------------------------
    always_comb begin
        nxt_fall = prev_ff & ~pin_a & wake_en; // R14 R17
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            prev_ff <= 8'h00;
        end else begin
            prev_ff <= pin_a;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= sleep_mode & (|nxt_fall); // R14
        end
    end

endmodule // gdd_wake_det
`default_nettype wire

// [rtl/gdd_port_ctrl.sv]
// Port data, direction, pull-high, wake and drive-level control
// Operation
// R1: port C bits 6..0, 0 output 1 input
// R2: port D bits 3..0 on large variant
// R3: unimplemented bits ignore writes, read zero
// R4: two-bit code selects drive level 0..3
// R5: first level register holds A/B fields
// R6: second level register holds C, D fields
// R7: level applies only to output pins
// R8: data and direction reset to ones
// R9: new output drives latched reset one
// R10: bit set/clear is read-modify-write
// R11: A/D-shared pins reset to analog
// R12: converter stays off until enabled
// R13: analog channel removes pull-high
// R14: falling edge on port A wakes
// R15: output pin reads latch, not pin
// R16: pull-high only on input pins
// R17: per-pin port A wake enable
// R18: gated level drives pad controls
`timescale 1ns/1ps
`default_nettype none
module gdd_port_ctrl #(
    parameter bit LARGE_VARIANT = 1'b1
) (
    input  wire logic                         clk_sys,
    input  wire logic                         sys_rst,
    input  wire gdd_pkg::gdd_cpu_s            cpu_req,
    input  wire logic [gdd_pkg::NPIN-1:0]     pin_in,
    input  wire logic                         sleep_mode,
    output logic [7:0]                        rd_data_ff,
    output logic                              busy_ff,
    output gdd_pkg::gdd_pad_s [gdd_pkg::NPIN-1:0] pad_ff,
    output logic [7:0]                        adc_analog_ff,
    output logic                              adc_on_ff,
    output logic                              wake_ff
);
    import gdd_pkg::*;

    localparam logic [7:0] MASK_PORT_D = LARGE_VARIANT ? MASK_PORT_D_LRG : MASK_PORT_D_SML;
    localparam logic [7:0] MASK_DRV_CD = LARGE_VARIANT ? MASK_DRV_CD_LRG : MASK_DRV_CD_SML;
    localparam logic [3:0][7:0] PORT_MASK = {MASK_PORT_D, MASK_PORT_C, MASK_PORT_B, MASK_PORT_A};

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [3:0][7:0] data_ff;
    logic [3:0][7:0] dir_ff;
    logic [3:0][7:0] pull_ff;
    logic [7:0]      wake_en_ff;
    logic [7:0]      drv_ab_ff;
    logic [7:0]      drv_cd_ff;
    logic [7:0]      ana_ff;
    logic [7:0]      adc_ff;
    gdd_state_e      state_ff;
    logic [7:0]      rmw_addr_ff;
    logic [2:0]      rmw_sel_ff;
    logic            rmw_set_ff;
    logic [7:0]      rmw_byte_ff;

    logic            wr_go;
    logic [7:0]      wr_addr;
    logic [7:0]      wr_val;
    logic [7:0]      rd_addr;
    logic [7:0]      rd_val;
    logic [3:0][7:0] pins_by_port;
    logic [NPIN-1:0] data_flat;
    logic [NPIN-1:0] dir_flat;
    logic [NPIN-1:0] pull_flat;
    logic [NPIN-1:0] ana_flat;
    logic [15:0]     drv_all;
    logic            is_port;
    logic [1:0]      port_idx;
    gdd_state_e      nxt_state;

    // ------------------------------------------------------------
    // Flattened pin views
    // ------------------------------------------------------------
    always_comb begin
        pins_by_port = {4'h0, pin_in[NPIN-1:PIN_BASE_D],
                        1'b0, pin_in[PIN_BASE_D-1:PIN_BASE_C],
                        1'b0, pin_in[PIN_BASE_C-1:PIN_BASE_B],
                        pin_in[PIN_BASE_B-1:PIN_BASE_A]};
        data_flat = {data_ff[3][3:0], data_ff[2][6:0], data_ff[1][6:0], data_ff[0]};
        dir_flat  = {dir_ff[3][3:0], dir_ff[2][6:0], dir_ff[1][6:0], dir_ff[0]};
        pull_flat = {pull_ff[3][3:0], pull_ff[2][6:0], pull_ff[1][6:0], pull_ff[0]};
        ana_flat  = {18'h00000, ana_ff};
        drv_all   = {drv_cd_ff, drv_ab_ff};
    end

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    always_comb begin
        rd_addr  = (state_ff == ST_RMW_RD) ? rmw_addr_ff : cpu_req.addr;
        is_port  = (rd_addr[7:4] == 4'h0) && (rd_addr[1:0] != 2'h3);
        port_idx = rd_addr[3:2];
        rd_val   = 8'h00;
        if (is_port) begin
            unique case (rd_addr[1:0])
                SUB_DATA: rd_val = ((data_ff[port_idx] & ~dir_ff[port_idx])
                                   | (pins_by_port[port_idx] & dir_ff[port_idx]))
                                   & PORT_MASK[port_idx]; // R15
                SUB_DIR:  rd_val = dir_ff[port_idx];
                SUB_PULL: rd_val = pull_ff[port_idx];
                default:  rd_val = 8'h00;
            endcase
        end else begin
            unique case (rd_addr)
                ADDR_WAKE:   rd_val = wake_en_ff;
                ADDR_DRV_AB: rd_val = drv_ab_ff;
                ADDR_DRV_CD: rd_val = drv_cd_ff; // R3
                ADDR_ANA:    rd_val = ana_ff;
                ADDR_ADC:    rd_val = adc_ff;
                default:     rd_val = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Bit set/clear sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:   if (cpu_req.bit_op) nxt_state = ST_RMW_RD; // R10
            ST_RMW_RD: nxt_state = ST_RMW_WR;
            ST_RMW_WR: nxt_state = ST_IDLE;
            default:   nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rmw_addr_ff <= 8'h00;
            rmw_sel_ff  <= 3'h0;
            rmw_set_ff  <= 1'b0;
        end else if (state_ff == ST_IDLE && cpu_req.bit_op) begin
            rmw_addr_ff <= cpu_req.addr;
            rmw_sel_ff  <= cpu_req.bit_sel;
            rmw_set_ff  <= cpu_req.bit_set;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rmw_byte_ff <= 8'h00;
        end else if (state_ff == ST_RMW_RD) begin
            rmw_byte_ff <= rd_val; // R10
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy_ff <= 1'b0;
        end else begin
            busy_ff <= (nxt_state != ST_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    always_comb begin
        wr_go   = 1'b0;
        wr_addr = cpu_req.addr;
        wr_val  = cpu_req.wdata;
        if (state_ff == ST_RMW_WR) begin
            wr_go   = 1'b1;
            wr_addr = rmw_addr_ff;
            wr_val  = rmw_byte_ff;
            wr_val[rmw_sel_ff] = rmw_set_ff; // R10
        end else if (state_ff == ST_IDLE && cpu_req.wr && !cpu_req.bit_op) begin
            wr_go = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Port data latches
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < NPORT; p++) begin
                data_ff[p] <= RST_DATA & PORT_MASK[p]; // R8 R9
            end
        end else if (wr_go && wr_addr[7:4] == 4'h0 && wr_addr[1:0] == SUB_DATA) begin
            for (int p = 0; p < NPORT; p++) begin
                if (wr_addr[3:2] == p[1:0]) begin
                    data_ff[p] <= wr_val & PORT_MASK[p];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Port direction
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < NPORT; p++) begin
                dir_ff[p] <= RST_DIR & PORT_MASK[p]; // R8
            end
        end else if (wr_go && wr_addr[7:4] == 4'h0 && wr_addr[1:0] == SUB_DIR) begin
            for (int p = 0; p < NPORT; p++) begin
                if (wr_addr[3:2] == p[1:0]) begin
                    dir_ff[p] <= wr_val & PORT_MASK[p]; // R1 R2 R3
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Port pull-high enables
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            for (int p = 0; p < NPORT; p++) begin
                pull_ff[p] <= RST_PULL;
            end
        end else if (wr_go && wr_addr[7:4] == 4'h0 && wr_addr[1:0] == SUB_PULL) begin
            for (int p = 0; p < NPORT; p++) begin
                if (wr_addr[3:2] == p[1:0]) begin
                    pull_ff[p] <= wr_val & PORT_MASK[p];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Wake enable and drive levels
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wake_en_ff <= RST_WAKE;
        end else if (wr_go && wr_addr == ADDR_WAKE) begin
            wake_en_ff <= wr_val; // R17
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            drv_ab_ff <= RST_DRV_AB;
        end else if (wr_go && wr_addr == ADDR_DRV_AB) begin
            drv_ab_ff <= wr_val & MASK_DRV_AB; // R5
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            drv_cd_ff <= RST_DRV_CD & MASK_DRV_CD;
        end else if (wr_go && wr_addr == ADDR_DRV_CD) begin
            drv_cd_ff <= wr_val & MASK_DRV_CD; // R6 R3
        end
    end

    // ------------------------------------------------------------
    // Analog select and converter enable
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ana_ff <= RST_ANA; // R11
        end else if (wr_go && wr_addr == ADDR_ANA) begin
            ana_ff <= wr_val;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            adc_ff <= RST_ADC; // R12
        end else if (wr_go && wr_addr == ADDR_ADC) begin
            adc_ff <= wr_val & MASK_ADC;
        end
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_ff <= 8'h00;
        end else if (cpu_req.rd && state_ff == ST_IDLE && !cpu_req.bit_op) begin
            rd_data_ff <= rd_val;
        end
    end

    // ------------------------------------------------------------
    // Pad controls, one per pin
    // ------------------------------------------------------------
    for (genvar i = 0; i < NPIN; i++) begin : g_pad
        localparam int LP = lvl_pos(i);
        always_ff @(posedge clk_sys or posedge sys_rst) begin
            if (sys_rst) begin
                pad_ff[i] <= '{dout: 1'b1, oe: 1'b0, pull: 1'b0, level: LVL_0};
            end else begin
                pad_ff[i].dout  <= data_flat[i]; // R9
                pad_ff[i].oe    <= ~dir_flat[i] & ~ana_flat[i]; // R1 R2 R11
                pad_ff[i].pull  <= pull_flat[i] & dir_flat[i] & ~ana_flat[i]; // R13 R16
                pad_ff[i].level <= (~dir_flat[i] & ~ana_flat[i])
                                   ? gdd_level_e'(drv_all[LP +: 2]) : LVL_0; // R4 R7 R18
            end
        end
    end

    // ------------------------------------------------------------
    // Converter status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            adc_analog_ff <= RST_ANA;
        end else begin
            adc_analog_ff <= ana_ff; // R11
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            adc_on_ff <= 1'b0;
        end else begin
            adc_on_ff <= adc_ff[ADC_EN_BIT]; // R12
        end
    end

    // ------------------------------------------------------------
    // Wake detection
    // ------------------------------------------------------------
    gdd_wake_det u_wake (
        .clk_sys    (clk_sys),
        .sys_rst    (sys_rst),
        .sleep_mode (sleep_mode),
        .pin_a      (pin_in[PIN_BASE_B-1:PIN_BASE_A]),
        .wake_en    (wake_en_ff),
        .wake_ff    (wake_ff)
    );

endmodule // gdd_port_ctrl
`default_nettype wire

// [test/gdd_monitor.sv]
// Checker of the port control block ports
`timescale 1ns/1ps
`default_nettype none
module gdd_monitor (
    input wire logic                   clk_sys,
    input wire logic                   sys_rst,
    input wire gdd_pkg::gdd_cpu_s      cpu_req,
    input wire logic [25:0]            pin_in,
    input wire logic                   sleep_mode,
    input wire logic [7:0]             rd_data_ff,
    input wire logic                   busy_ff,
    input wire gdd_pkg::gdd_pad_s [25:0] pad_ff,
    input wire logic [7:0]             adc_analog_ff,
    input wire logic                   adc_on_ff,
    input wire logic                   wake_ff
);
    import gdd_pkg::*;
    logic [7:0] prev_a_ff;
    logic [7:0] fall;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) prev_a_ff <= 8'hFF;
        else prev_a_ff <= pin_in[7:0];
    end
    assign fall = prev_a_ff & ~pin_in[7:0];
    for (genvar i = 0; i < NPIN; i++) begin : g_pin
        a_level_gated: assert property (!pad_ff[i].oe |-> pad_ff[i].level == LVL_0)
            else $error("level on undriven pin");
        a_pull_input: assert property (pad_ff[i].oe |-> !pad_ff[i].pull)
            else $error("pull on driven pin");
    end
    for (genvar i = 0; i < 8; i++) begin : g_ana
        a_analog_nopull: assert property (adc_analog_ff[i] && $past(adc_analog_ff[i])
            |-> !pad_ff[i].pull && !pad_ff[i].oe) else $error("analog pin not released");
    end
    a_busy_cause: assert property ($rose(busy_ff)
        |-> $past(cpu_req.bit_op) || $past(cpu_req.bit_op, 2)) else $error("busy uncaused");
    a_busy_span: assert property ($rose(busy_ff) |=> busy_ff ##1 !busy_ff)
        else $error("bit op length");
    a_read_hold: assert property (!$past(cpu_req.rd) |-> $stable(rd_data_ff))
        else $error("read data moved");
    a_wake_cause: assert property (wake_ff |-> ($past(sleep_mode) || $past(sleep_mode, 2))
        && ($past(|fall) || $past(|fall, 2))) else $error("wake uncaused");
    a_pads_quiet: assert property ($changed(pad_ff) |-> $past(cpu_req.wr)
        || $past(cpu_req.wr, 2) || $past(busy_ff) || $past(busy_ff, 2)) else $error("pad moved");
    a_analog_cpu: assert property ($changed(adc_analog_ff)
        |-> $past(cpu_req.wr, 2) || $past(busy_ff, 2)) else $error("analog moved");
    c_bit_op: cover property ($rose(busy_ff));
    c_wake: cover property (wake_ff);
    c_top_level: cover property (pad_ff[16].oe && pad_ff[16].level == LVL_3);
endmodule // gdd_monitor
bind gdd_port_ctrl gdd_monitor gdd_monitor_inst (.clk_sys, .sys_rst, .cpu_req, .pin_in,
    .sleep_mode, .rd_data_ff, .busy_ff, .pad_ff, .adc_analog_ff, .adc_on_ff, .wake_ff);
`default_nettype wire

// [test/gdd_pin_model.sv]
// Circuitry attached to the port pins
`timescale 1ns/1ps
`default_nettype none
module gdd_pin_model (
    input  wire gdd_pkg::gdd_pad_s [25:0] pad,
    input  wire logic [25:0]            ext_level,
    input  wire logic [25:0]            short_mask,
    output logic [25:0]                 pin_in
);
    import gdd_pkg::*;
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            if (short_mask[i]) pin_in[i] = ~pad[i].dout;
            else if (pad[i].oe) pin_in[i] = pad[i].dout;
            else pin_in[i] = ext_level[i];
        end
    end
endmodule // gdd_pin_model
`default_nettype wire

// [test/tb_gpio_direction_drive_control.sv]
// Testbench of the port direction and drive control block
`timescale 1ns/1ps
`default_nettype none
module tb_gpio_direction_drive_control;
    import gdd_pkg::*;
    logic               clk_sys = 1'b0;
    logic               sys_rst = 1'b1;
    gdd_cpu_s           cpu_req = '0;
    logic               sleep_mode = 1'b0;
    logic [25:0]        ext_level = '1;
    logic [25:0]        short_mask = '0;
    logic [25:0]        pin_in;
    logic [7:0]         rd_data_ff;
    logic [7:0]         adc_analog_ff;
    logic               busy_ff;
    logic               adc_on_ff;
    logic               wake_ff;
    gdd_pad_s [25:0]    pad_ff;
    logic [7:0]         rv;
    int                 num_errors = 0;
    int                 tests_run = 0;
    int                 cycles = 0;
    gdd_port_ctrl #(.LARGE_VARIANT(1'b1)) gdd_port_ctrl_inst (.clk_sys, .sys_rst, .cpu_req,
        .pin_in, .sleep_mode, .rd_data_ff, .busy_ff, .pad_ff, .adc_analog_ff, .adc_on_ff, .wake_ff);
    gdd_pin_model gdd_pin_model_inst (.pad(pad_ff), .ext_level, .short_mask, .pin_in);
    initial forever #12.5 clk_sys = ~clk_sys;
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test;
        end
    end
    task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic chk1(input string s, input logic e, input logic g);
        chk8(s, {7'h0, e}, {7'h0, g});
    endtask
    task automatic bus(input logic [22:0] r);
        @(posedge clk_sys);
        cpu_req <= r;
        @(posedge clk_sys);
        cpu_req <= '0;
        @(negedge clk_sys);
        rv = rd_data_ff;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus({7'h40, a, d});
    endtask
    task automatic rc(input string s, input logic [7:0] a, input logic [7:0] e);
        bus({7'h20, a, 8'h00});
        chk8(s, e, rv);
    endtask
    task automatic bitop(input logic [7:0] a, input logic st, input logic [2:0] b);
        bus({3'h1, st, b, a, 8'h00});
        repeat (3) @(negedge clk_sys);
        chk1("busy", 1'b0, busy_ff);
    endtask
    task automatic settle;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic watch(input logic e, input string s);
        logic seen;
        seen = 1'b0;
        repeat (6) begin
            @(negedge clk_sys);
            if (wake_ff === 1'b1) seen = 1'b1;
        end
        chk1(s, e, seen);
        @(posedge clk_sys);
    endtask
    task automatic t_reset;
        logic [7:0] ad [10] = '{8'h01, 8'h05, 8'h09, 8'h0D, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13};
        logic [7:0] ex [10] = '{8'hFF, 8'h7F, 8'h7F, 8'h0F, 8'h00, 8'h00, 8'h55, 8'h15, 8'hFF, 8'h00};
        for (int i = 0; i < 10; i++) rc("reset reg", ad[i], ex[i]);
        chk1("dout", 1'b1, pad_ff[20].dout);
        chk1("oe", 1'b0, pad_ff[20].oe);
        chk1("adc on", 1'b0, adc_on_ff);
        chk8("analog", 8'hFF, adc_analog_ff);
        $display("reset done");
    endtask
    task automatic t_dir;
        wr(8'h09, 8'hD5);
        rc("c dir", 8'h09, 8'h55);
        wr(8'h0D, 8'hF0);
        rc("d dir", 8'h0D, 8'h00);
        settle;
        chk1("c0 oe", 1'b0, pad_ff[15].oe);
        chk1("c1 oe", 1'b1, pad_ff[16].oe);
        chk1("c1 dout", 1'b1, pad_ff[16].dout);
        chk1("d0 oe", 1'b1, pad_ff[22].oe);
        $display("direction done");
    endtask
    task automatic t_level;
        logic [1:0] c;
        wr(ADDR_ANA, 8'h00);
        wr(8'h01, 8'hF0);
        wr(8'h05, 8'h00);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(ADDR_DRV_AB, {c + 2'h3, c + 2'h2, c + 2'h1, c});
            wr(ADDR_DRV_CD, {2'h3, c + 2'h2, c + 2'h1, c});
            rc("cd lvl", ADDR_DRV_CD, {2'h0, c + 2'h2, c + 2'h1, c});
            settle;
            chk8("a0", {6'h0, c}, {6'h0, pad_ff[0].level});
            chk8("a4", 8'h00, {6'h0, pad_ff[4].level});
            chk8("b0", {6'h0, c + 2'h2}, {6'h0, pad_ff[8].level});
            chk8("b4", {6'h0, c + 2'h3}, {6'h0, pad_ff[12].level});
            chk8("c1", {6'h0, c}, {6'h0, pad_ff[16].level});
            chk8("c5", {6'h0, c + 2'h1}, {6'h0, pad_ff[20].level});
            chk8("c0", 8'h00, {6'h0, pad_ff[15].level});
            chk8("d0", {6'h0, c + 2'h2}, {6'h0, pad_ff[22].level});
        end
        $display("level done");
    endtask
    task automatic t_pull;
        wr(ADDR_ANA, 8'hFF);
        wr(8'h02, 8'hFF);
        settle;
        chk1("a4 pull", 1'b0, pad_ff[4].pull);
        chk1("a0 oe", 1'b0, pad_ff[0].oe);
        chk8("analog", 8'hFF, adc_analog_ff);
        wr(ADDR_ANA, 8'h00);
        settle;
        chk1("a4 pull", 1'b1, pad_ff[4].pull);
        chk1("a0 pull", 1'b0, pad_ff[0].pull);
        chk8("digital", 8'h00, adc_analog_ff);
        $display("pull done");
    endtask
    task automatic t_latch;
        wr(8'h08, 8'h00);
        @(posedge clk_sys);
        short_mask[16] <= 1'b1;
        settle;
        rc("latch", 8'h08, 8'h55);
        @(posedge clk_sys);
        short_mask <= '0;
        bitop(8'h08, 1'b1, 3'h1);
        chk1("c1 dout", 1'b1, pad_ff[16].dout);
        wr(8'h09, 8'h00);
        rc("rmw byte", 8'h08, 8'h57);
        bitop(8'h09, 1'b1, 3'h6);
        rc("dir bit", 8'h09, 8'h40);
        bitop(8'h09, 1'b0, 3'h6);
        rc("dir clr", 8'h09, 8'h00);
        $display("latch done");
    endtask
    task automatic t_wake;
        wr(8'h03, 8'h30);
        @(posedge clk_sys);
        sleep_mode <= 1'b1;
        ext_level[6] <= 1'b0;
        watch(1'b0, "masked wake");
        ext_level[4] <= 1'b0;
        watch(1'b1, "wake");
        sleep_mode <= 1'b0;
        ext_level[5] <= 1'b0;
        watch(1'b0, "awake wake");
        ext_level <= '1;
        rc("unmapped", 8'h3F, 8'h00);
        wr(ADDR_ADC, 8'hFF);
        rc("adc reg", ADDR_ADC, 8'h01);
        chk1("adc on", 1'b1, adc_on_ff);
        $display("wake done");
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset;
        t_dir;
        t_level;
        t_pull;
        t_latch;
        t_wake;
        stop_test;
    end
endmodule // tb_gpio_direction_drive_control
`default_nettype wire
